// ### bea_cell_array.sv
`timescale 1ns/1ps
`default_nettype none
module bea_cell_array #(
  parameter int unsigned ROWS = bea_pkg::NV_ROWS,
  parameter int unsigned COLS = bea_pkg::NV_COLS,
  parameter logic INIT_VALUE = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic [$clog2(ROWS)-1:0] row_i,
  input wire logic [$clog2(COLS)-1:0] col_i,
  input wire logic hv_i,
  input wire logic program_i,
  input wire logic row_erase_i,
  input wire logic bulk_erase_i,
  output logic rd_bit_o
);
  import bea_pkg::*;
  localparam int unsigned CELLS = ROWS * COLS;
  localparam int unsigned AW = $clog2(CELLS);
  // nonvolatile: no reset; power-up value only for simulation and fpga
  logic [CELLS-1:0] cells = {CELLS{INIT_VALUE}};
  logic [CELLS-1:0] next_cells;
  wire logic [AW-1:0] cell_idx = {row_i, col_i};
  wire logic do_bulk = hv_i & bulk_erase_i;
  wire logic do_row = hv_i & row_erase_i & ~bulk_erase_i;
  wire logic do_pgm = hv_i & program_i & ~row_erase_i & ~bulk_erase_i;

  always_comb begin
    next_cells = cells;
    for (int i = 0; i < CELLS; i++) begin
      if (do_bulk) begin
        next_cells[i] = 1'b0;
      end else if (do_row && (i / COLS) == int'(row_i)) begin
        next_cells[i] = 1'b0;
      end else if (do_pgm && i == int'(cell_idx)) begin
        next_cells[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    cells <= next_cells;
  end

  // single sense path through the column selector
  assign rd_bit_o = cells[cell_idx];
endmodule : bea_cell_array
`default_nettype wire

// ### bea_nv_chk.sv
`timescale 1ns/1ps
`default_nettype none
module bea_nv_chk
  import bea_pkg::*;
#(
  parameter int unsigned PUMP_START_CYCLES = bea_pkg::PUMP_START_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [1:0] avs_response_o,
  input wire logic pump_run_o,
  input wire logic pump_ready_o,
  input wire logic pump_clk_o,
  input wire logic pump_clk_from_bus_o,
  input wire logic column_zero_flag_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // slack of three cycles for the registered state and output stages
  localparam int RAMP_MAX = PUMP_START_CYCLES + 3;
  wire logic req_new = (avs_read_i || avs_write_i) && avs_waitrequest_o;
  wire logic is_sel = avs_address_i == CELL_SELECT_ADDR;
  wire logic is_sts = avs_address_i == NV_STATUS_CONTROL_ADDR;
  wire logic commit = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  answer_one_wait_a: assert property (req_new |=> !avs_waitrequest_o)
    else $error("no answer one cycle after request");
  wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  decode_err_a: assert property (req_new && avs_read_i && !is_sel && !is_sts |=>
    avs_response_o == RESP_DECODEERROR && avs_readdata_o == 32'h0)
    else $error("unmapped read not refused");
  decode_ok_a: assert property (req_new && (is_sel || is_sts) |=> avs_response_o == RESP_OKAY)
    else $error("mapped access not okay");
  status_bit1_a: assert property (req_new && avs_read_i && is_sts |=>
    avs_readdata_o[1] == 1'b0 && avs_readdata_o[31:8] == 24'h0)
    else $error("status unused bits not zero");
  ready_in_run_a: assert property (pump_ready_o |-> pump_run_o)
    else $error("pump ready without pump running");
  ramp_then_ready_a: assert property ($rose(pump_run_o) |->
    !pump_ready_o ##[1:RAMP_MAX] pump_ready_o)
    else $error("pump ramp length wrong");
  clk_idle_a: assert property ((!pump_run_o) [*2] |-> !pump_clk_o)
    else $error("pump clock runs while pump off");
  colz_track_a: assert property (commit && is_sel |->
    ##2 column_zero_flag_o == ($past(avs_writedata_i[2:0], 2) == 3'h0))
    else $error("column zero flag does not follow select");
  clk_src_a: assert property (commit && is_sts |->
    ##2 pump_clk_from_bus_o == $past(avs_writedata_i[6], 2))
    else $error("pump clock source not taken");
endmodule : bea_nv_chk
bind bea_nv_ctrl bea_nv_chk #(.PUMP_START_CYCLES(PUMP_START_CYCLES)) chk_i (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
  .pump_run_o(pump_run_o), .pump_ready_o(pump_ready_o), .pump_clk_o(pump_clk_o),
  .pump_clk_from_bus_o(pump_clk_from_bus_o), .column_zero_flag_o(column_zero_flag_o));
`default_nettype wire

// ### bea_nv_ctrl.sv
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module bea_nv_ctrl #(
  parameter int unsigned ROWS = bea_pkg::NV_ROWS,
  parameter int unsigned COLS = bea_pkg::NV_COLS,
  parameter int unsigned PUMP_START_CYCLES = bea_pkg::PUMP_START_CYC,
  parameter logic ARRAY_INIT = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  input wire logic ring_osc_i,
  output logic pump_run_o,
  output logic pump_ready_o,
  output logic pump_clk_o,
  output logic pump_clk_from_bus_o,
  output logic column_zero_flag_o,
  output logic sense_data_o
);
  import bea_pkg::*;

  localparam int unsigned ROW_W = $clog2(ROWS);
  localparam int unsigned COL_W = $clog2(COLS);
  localparam int unsigned CNT_W = (PUMP_START_CYCLES > 1) ?
    $clog2(PUMP_START_CYCLES + 1) : 1;
  localparam logic [CNT_W-1:0] START_LOAD = CNT_W'(PUMP_START_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  // software visible state
  logic [7:0] cell_select;
  logic cell_program;
  logic row_erase;
  logic bulk_erase;
  logic pump_enable;
  logic pump_clock_source;
  logic sense_bit;

  // bus handshake
  logic next_waitrequest;
  logic [31:0] next_readdata;
  logic [1:0] next_response;

  // pump sequencing
  bea_pump_state_t pump_state;
  bea_pump_state_t next_pump_state;
  logic [CNT_W-1:0] ramp_cnt;
  logic [CNT_W-1:0] next_ramp_cnt;

  // ring oscillator sampling
  logic ring_meta;
  logic ring_sync;
  logic bus_div;

  // array sense path
  logic array_rd_bit;

  // address decode
  wire logic bus_req = avs_read_i | avs_write_i;
  wire logic hit_select = (avs_address_i == CELL_SELECT_ADDR);
  wire logic hit_status = (avs_address_i == NV_STATUS_CONTROL_ADDR);
  wire logic hit_any = hit_select | hit_status;
  // first edge of a request drops waitrequest, the second commits
  wire logic bus_commit = bus_req & ~avs_waitrequest_o;
  wire logic bus_accept = bus_req & avs_waitrequest_o;
  wire logic lane0_wr = bus_commit & avs_write_i & avs_byteenable_i[0];
  wire logic wr_select = lane0_wr & hit_select;
  wire logic wr_status = lane0_wr & hit_status;

  // cell address fields
  wire logic [ROW_W-1:0] sel_row = cell_select[SEL_ROW_MSB:SEL_ROW_LSB];
  wire logic [COL_W-1:0] sel_col = cell_select[SEL_COL_MSB:SEL_COL_LSB];
  wire logic col_zero = (sel_col == '0);

  // pump request terms
  wire logic any_op = cell_program | row_erase | bulk_erase;
  wire logic pump_start_req = pump_enable & any_op;
  wire logic pump_all_clear = ~any_op & ~pump_enable;
  wire logic pump_active = (pump_state != BEA_PUMP_OFF);
  wire logic hv_present = (pump_state == BEA_PUMP_ON);

  // readback words; status bit 1 stays zero, narrow data in the low byte
  wire logic [31:0] select_word = {24'h000000, cell_select};
  wire logic [7:0] status_byte = {
    sense_bit,
    pump_clock_source,
    pump_enable,
    bulk_erase,
    row_erase,
    cell_program,
    1'b0,
    col_zero
  };
  wire logic [31:0] status_word = {24'h000000, status_byte};
  wire logic [31:0] rd_mux = hit_select ? select_word :
                             hit_status ? status_word : 32'h00000000;

  // written control bits; flag and data positions are dropped
  wire logic wd_pgm = avs_writedata_i[STS_PGM_BIT];
  wire logic wd_row = avs_writedata_i[STS_ROW_ERASE_BIT];
  wire logic wd_bulk = avs_writedata_i[STS_BULK_ERASE_BIT];
  wire logic wd_pen = avs_writedata_i[STS_PUMP_EN_BIT];
  wire logic wd_pclk = avs_writedata_i[STS_PUMP_CLK_BIT];

  // waitrequest and read data
  always_comb begin
    next_waitrequest = 1'b1;
    if (bus_accept) begin
      next_waitrequest = 1'b0;
    end
  end

  always_comb begin
    next_readdata = avs_readdata_o;
    next_response = avs_response_o;
    if (bus_accept) begin
      next_response = hit_any ? RESP_OKAY : RESP_DECODEERROR;
      if (avs_read_i) begin
        next_readdata = rd_mux;
      end else begin
        next_readdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
      avs_response_o <= RESP_OKAY;
    end else begin
      avs_waitrequest_o <= next_waitrequest;
      avs_readdata_o <= next_readdata;
      avs_response_o <= next_response;
    end
  end

  // cell select register, spare bit is plain storage
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cell_select <= CELL_SELECT_RST;
    end else if (wr_select) begin
      cell_select <= avs_writedata_i[7:0];
    end
  end

  // control bits of the status/control register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cell_program <= CTRL_BIT_RST;
      row_erase <= CTRL_BIT_RST;
      bulk_erase <= CTRL_BIT_RST;
      pump_enable <= CTRL_BIT_RST;
      pump_clock_source <= CTRL_BIT_RST;
    end else if (wr_status) begin
      cell_program <= wd_pgm;
      row_erase <= wd_row;
      bulk_erase <= wd_bulk;
      pump_enable <= wd_pen;
      pump_clock_source <= wd_pclk;
    end
  end

  // pump sequencer: ramp up for the startup time, then hold voltage
  always_comb begin
    next_pump_state = pump_state;
    next_ramp_cnt = ramp_cnt;
    case (pump_state)
      BEA_PUMP_OFF: begin
        if (pump_start_req) begin
          next_pump_state = BEA_PUMP_RAMP;
          next_ramp_cnt = START_LOAD;
        end
      end
      BEA_PUMP_RAMP: begin
        if (pump_all_clear) begin
          next_pump_state = BEA_PUMP_OFF;
        end else if (ramp_cnt <= CNT_ONE) begin
          next_pump_state = BEA_PUMP_ON;
          next_ramp_cnt = '0;
        end else begin
          next_ramp_cnt = ramp_cnt - CNT_ONE;
        end
      end
      BEA_PUMP_ON: begin
        // keeps running even with enable low while an op bit is set
        if (pump_all_clear) begin
          next_pump_state = BEA_PUMP_OFF;
        end
      end
      default: begin
        next_pump_state = BEA_PUMP_OFF;
        next_ramp_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pump_state <= BEA_PUMP_OFF;
      ramp_cnt <= '0;
    end else begin
      pump_state <= next_pump_state;
      ramp_cnt <= next_ramp_cnt;
    end
  end

  // ring oscillator comes from outside this clock domain
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ring_meta <= 1'b0;
      ring_sync <= 1'b0;
    end else begin
      ring_meta <= ring_osc_i;
      ring_sync <= ring_meta;
    end
  end

  // bus clock source gives half rate; pump stage wants a square wave
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bus_div <= 1'b0;
    end else if (pump_active) begin
      bus_div <= ~bus_div;
    end else begin
      bus_div <= 1'b0;
    end
  end

  wire logic pump_clk_src = pump_clock_source ? bus_div : ring_sync;
  wire logic next_pump_clk = pump_active & pump_clk_src;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pump_clk_o <= 1'b0;
      pump_run_o <= 1'b0;
      pump_ready_o <= 1'b0;
      pump_clk_from_bus_o <= 1'b0;
    end else begin
      pump_clk_o <= next_pump_clk;
      pump_run_o <= pump_active;
      pump_ready_o <= hv_present;
      pump_clk_from_bus_o <= pump_clock_source;
    end
  end

  // cell array; writes only with high voltage present
  bea_cell_array #(
    .ROWS(ROWS),
    .COLS(COLS),
    .INIT_VALUE(ARRAY_INIT)
  ) u_array (
    .core_clk_i(core_clk_i),
    .row_i(sel_row),
    .col_i(sel_col),
    .hv_i(hv_present),
    .program_i(cell_program),
    .row_erase_i(row_erase),
    .bulk_erase_i(bulk_erase),
    .rd_bit_o(array_rd_bit)
  );

  // status sense bit is raw while controls are active; sense_data_o is held low then
  wire logic sense_valid = ~any_op & ~pump_enable;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sense_bit <= array_rd_bit;
    end else begin
      sense_bit <= array_rd_bit;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      column_zero_flag_o <= 1'b1;
      sense_data_o <= array_rd_bit;
    end else begin
      column_zero_flag_o <= col_zero;
      sense_data_o <= array_rd_bit & sense_valid;
    end
  end
endmodule : bea_nv_ctrl
`default_nettype wire

// ### bea_pkg.sv
package bea_pkg;
  localparam int unsigned CLK_FREQ_HZ = 20_000_000;
  localparam int unsigned BUS_CLK_MIN_HZ = 1_000_000;
  localparam int unsigned PUMP_START_NS = 1000;
  localparam int unsigned PUMP_START_CYC =
    (PUMP_START_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned NV_ROWS = 16;
  localparam int unsigned NV_COLS = 8;
  localparam logic [7:0] CELL_SELECT_IDX = 8'h0e;
  localparam logic [7:0] NV_STATUS_CONTROL_IDX = 8'h0f;
  localparam logic [7:0] CELL_SELECT_ADDR = {CELL_SELECT_IDX[5:0], 2'b00};
  localparam logic [7:0] NV_STATUS_CONTROL_ADDR = {NV_STATUS_CONTROL_IDX[5:0], 2'b00};
  localparam logic [7:0] CELL_SELECT_RST = 8'h00;
  localparam int unsigned SEL_SPARE_BIT = 7;
  localparam int unsigned SEL_ROW_MSB = 6;
  localparam int unsigned SEL_ROW_LSB = 3;
  localparam int unsigned SEL_COL_MSB = 2;
  localparam int unsigned SEL_COL_LSB = 0;
  localparam int unsigned STS_COLZ_BIT = 0;
  localparam int unsigned STS_PGM_BIT = 2;
  localparam int unsigned STS_ROW_ERASE_BIT = 3;
  localparam int unsigned STS_BULK_ERASE_BIT = 4;
  localparam int unsigned STS_PUMP_EN_BIT = 5;
  localparam int unsigned STS_PUMP_CLK_BIT = 6;
  localparam int unsigned STS_DATA_BIT = 7;
  localparam logic CTRL_BIT_RST = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECODEERROR = 2'b11;
  typedef enum logic [1:0] {
    BEA_PUMP_OFF = 2'b00,
    BEA_PUMP_RAMP = 2'b01,
    BEA_PUMP_ON = 2'b10
  } bea_pump_state_t;
endpackage : bea_pkg

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bea_pkg::*;
  localparam int unsigned RAMP = 2;
  logic core_clk_i, rst_i, avs_read_i, avs_write_i;
  logic ring_osc_i = 1'b0;
  logic [7:0] avs_address_i, s;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic [3:0] avs_byteenable_i;
  logic [1:0] avs_response_o, rsp;
  logic avs_waitrequest_o, pump_run_o, pump_ready_o, pump_clk_o, pump_clk_from_bus_o;
  logic column_zero_flag_o, sense_data_o;
  logic mem [0:127];
  logic [7:0] m_sel, m_ctrl;
  int n_fail, checks_done;
  bea_nv_ctrl #(.PUMP_START_CYCLES(RAMP)) uut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
    .ring_osc_i(ring_osc_i), .pump_run_o(pump_run_o), .pump_ready_o(pump_ready_o),
    .pump_clk_o(pump_clk_o), .pump_clk_from_bus_o(pump_clk_from_bus_o),
    .column_zero_flag_o(column_zero_flag_o), .sense_data_o(sense_data_o));
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) ring_osc_i <= ~ring_osc_i;
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                     input logic [3:0] be);
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, wd};
    avs_byteenable_i <= be;
    // no cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge core_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    rsp = avs_response_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (wr && be[0] && a == CELL_SELECT_ADDR) m_sel = wd;
    if (wr && be[0] && a == NV_STATUS_CONTROL_ADDR) m_ctrl = wd & 8'h7c;
    // two idle edges let the registered flag and sense bit settle
    repeat (2) @(posedge core_clk_i);
  endtask : bus
  function automatic logic [7:0] exp_sts();
    logic d;
    d = (m_ctrl[5:2] == 4'h0) ? mem[m_sel[6:0]] : 1'b0;
    return {d, m_ctrl[6:2], 1'b0, m_sel[2:0] == 3'h0};
  endfunction : exp_sts
  task automatic rd_sts();
    logic [7:0] m;
    // sensed bit has no defined value while a program, erase or pump enable bit is set
    m = (m_ctrl[5:2] != 4'h0) ? 8'h7f : 8'hff;
    bus(1'b0, NV_STATUS_CONTROL_ADDR, 8'h00, 4'hf);
    chk("status", rd & {24'hffffff, m}, {24'h0, exp_sts() & m});
    if (m_ctrl[5:2] == 4'h0) chk("sense_out", sense_data_o, {24'h0, exp_sts() >> 7});
  endtask : rd_sts
  task automatic pump_op(input logic [7:0] v);
    int n;
    bus(1'b1, NV_STATUS_CONTROL_ADDR, v, 4'h1);
    n = 0;
    while (pump_ready_o !== 1'b1 && n < 100) begin
      @(posedge core_clk_i);
      n++;
    end
    chk("pump_ready", pump_ready_o, 1'b1);
    chk("pump_clk_src", pump_clk_from_bus_o, v[6]);
    rd_sts();
    if (v[4]) for (int i = 0; i < 128; i++) mem[i] = 1'b0;
    else if (v[3]) for (int c = 0; c < 8; c++) mem[{m_sel[6:3], 3'(c)}] = 1'b0;
    else if (v[2]) mem[m_sel[6:0]] = 1'b1;
    bus(1'b1, NV_STATUS_CONTROL_ADDR, 8'h20 | (v & 8'h40), 4'h1);
    chk("pump_hold", pump_run_o, 1'b1);
    bus(1'b1, NV_STATUS_CONTROL_ADDR, 8'h00, 4'h1);
    repeat (2) @(posedge core_clk_i);
    chk("pump_off", pump_run_o, 1'b0);
  endtask : pump_op
  initial begin
    repeat (40000) @(posedge core_clk_i);
    n_fail++;
    give_verdict();
  end
  initial begin
    rst_i = 1'b1;
    {avs_read_i, avs_write_i} = 2'b00;
    avs_address_i = 8'h00;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'h0;
    {n_fail, checks_done} = 0;
    {m_sel, m_ctrl} = 16'h0;
    for (int i = 0; i < 128; i++) mem[i] = 1'b0;
    rd = $urandom(62);
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    chk("colz_reset", column_zero_flag_o, 1'b1);
    bus(1'b0, CELL_SELECT_ADDR, 8'h00, 4'hf);
    chk("sel_reset", rd, 32'h0);
    rd_sts();
    pump_op(8'hfb);
    pump_op(8'h30);
    bus(1'b1, NV_STATUS_CONTROL_ADDR, 8'h20, 4'h1);
    repeat (RAMP + 4) @(posedge core_clk_i);
    chk("pump_en_alone", pump_run_o, 1'b0);
    bus(1'b1, NV_STATUS_CONTROL_ADDR, 8'h04, 4'h1);
    repeat (RAMP + 4) @(posedge core_clk_i);
    chk("pgm_alone", pump_run_o, 1'b0);
    rd_sts();
    bus(1'b1, NV_STATUS_CONTROL_ADDR, 8'h00, 4'h1);
    for (int k = 0; k < 10; k++) begin
      s = 8'($urandom);
      bus(1'b1, CELL_SELECT_ADDR, s, 4'h1);
      pump_op(8'h24 | {1'b0, 1'($urandom), 6'h0});
    end
    pump_op(8'h28);
    bus(1'b0, 8'h40, 8'h00, 4'hf);
    chk("unmapped", {rd[31:2], rsp}, {30'h0, RESP_DECODEERROR});
    bus(1'b1, 8'h00, 8'h55, 4'h1);
    bus(1'b1, CELL_SELECT_ADDR, 8'h55, 4'h0);
    bus(1'b0, CELL_SELECT_ADDR, 8'h00, 4'hf);
    chk("sel_ignored", rd, {24'h0, m_sel});
    for (int i = 0; i < 128; i++) begin
      s = {1'($urandom), 7'(i)};
      bus(1'b1, CELL_SELECT_ADDR, s, 4'h1);
      chk("colz", column_zero_flag_o, s[2:0] == 3'h0);
      bus(1'b0, CELL_SELECT_ADDR, 8'h00, 4'hf);
      chk("sel", rd, {24'h0, m_sel});
      rd_sts();
    end
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
